// >>> logic/rio_irq_out.sv
// Interrupt output logic: flags, pin masks, tick pulse and APB registers
//
// Functional notes
// - Two separate open-drain interrupt pins, asserted by driving low.
// - With every source disabled neither pin is ever driven low.
// - Pulse-select 1 gives a tick pulse; 0 holds until flag cleared.
// - All non-tick sources give a level following their own flag.
// - Host clears tick, alarm, stamp and switch-over flags by command.
// - Watchdog and battery-low flags read-only; battery-low self-clears.
// - Minute/second enables: none, per minute, or per second.
// - Tick flag set on the enabled counter increment.
// - Tick pulse timed by 64 Hz strobe, one period long.
// - Clearing the tick flag ends a running pulse at once.
// - Watchdog enable: pin follows watchdog flag as a level.
// - Alarm enable: pin follows alarm flag, released on clear.
// - Stamp-on-switchover disabled: switch-over never touches group four.
// - Enabled and flag clear: capture group four, then set flag.
// - Enabled and flag set: group four kept, further events ignored.
// - Per-pin mask bit per source, 1 blocks, reset to 1.
// - Stamp enable: pin follows the matching stamp flag as a level.
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "rio_cfg.svh"
module rio_irq_out (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [`RIO_AW-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [`RIO_DW-1:0] pwdata,
	output logic      [`RIO_DW-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              second_tick,
	input  wire logic              minute_tick,
	input  wire logic              tick_64hz,
	input  wire logic              alarm_event,
	input  wire logic              watchdog_level,
	input  wire logic              switchover_pin,
	input  wire logic              batt_low_pin,
	input  wire logic [3:0]        stamp_pins_n,
	output logic                   irq_out_a_o,
	output logic                   irq_out_a_oe,
	output logic                   irq_out_b_o,
	output logic                   irq_out_b_oe,
	output logic      [3:0]        stamp_capture,
	output logic                   irq
);

	// ------------------------------------------------------------------------
	// Pin request decode, shared by both pins
	// ------------------------------------------------------------------------
	function automatic logic pin_request(
		input logic [`RIO_CTRL_W-1:0] ctl,
		input logic [`RIO_FLAG_W-1:0] flg,
		input logic                   tick_src,
		input logic [`RIO_M1_W-1:0]   m1,
		input logic [`RIO_M2_W-1:0]   m2
	);
		logic req;
		req = 1'b0;
		// Second tick masked by its own bit; minute only when seconds off
		if (ctl[`RIO_C_SEC] && !m1[`RIO_M1_SEC] && tick_src)
			req = 1'b1;
		if (ctl[`RIO_C_MIN] && !ctl[`RIO_C_SEC] && !m1[`RIO_M1_MIN]
			&& tick_src)
			req = 1'b1;
		if (ctl[`RIO_C_WD] && !m1[`RIO_M1_WD] && flg[`RIO_F_WD])
			req = 1'b1;
		if (ctl[`RIO_C_AL] && !m1[`RIO_M1_AL] && flg[`RIO_F_AL])
			req = 1'b1;
		if (ctl[`RIO_C_BSW] && !m1[`RIO_M1_BSW] && flg[`RIO_F_BSW])
			req = 1'b1;
		if (ctl[`RIO_C_BLOW] && !m1[`RIO_M1_BLOW] && flg[`RIO_F_BLOW])
			req = 1'b1;
		for (int i = 0; i < 4; i++) begin
			// Stamp mask bits run in reverse order to the flags
			if (ctl[`RIO_C_TS + i] && !m2[3 - i] && flg[`RIO_F_TS + i])
				req = 1'b1;
		end
		return req;
	endfunction

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [`RIO_CTRL_W-1:0]  ctrl;
	logic [`RIO_FLAG_W-1:0]  irq_mask;
	logic [`RIO_M1_W-1:0]    mask_a1;
	logic [`RIO_M2_W-1:0]    mask_a2;
	logic [`RIO_M1_W-1:0]    mask_b1;
	logic [`RIO_M2_W-1:0]    mask_b2;
	logic                    tick_flag;
	logic                    alarm_flag;
	logic                    switchover_flag;
	logic [3:0]              stamp_flags;
	logic                    watchdog_flag;
	logic                    batt_low_flag;
	rio_pkg::rio_pulse_state_t pulse_state;
	rio_pkg::rio_pulse_state_t next_pulse_state;

	// ------------------------------------------------------------------------
	// Pin synchronisation and edge detection
	// ------------------------------------------------------------------------
	logic [`RIO_SYNC_W-1:0] pin_sync;
	logic [`RIO_SYNC_W-1:0] pin_prev;

	rio_sync #(
		.WIDTH(`RIO_SYNC_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({switchover_pin, batt_low_pin, stamp_pins_n}),
		.dout    (pin_sync)
	);

	// Same reset value as the synchroniser, so no false edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_prev <= '0;
		else
			pin_prev <= pin_sync;
	end

	wire [3:0] stamp_now   = pin_sync[3:0];
	wire       batt_low_now = pin_sync[4];
	wire       switch_now  = pin_sync[5];
	wire [3:0] stamp_fall  = pin_prev[3:0] & ~stamp_now;
	wire       switch_rise = switch_now & ~pin_prev[5];

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	// One wait state: pready rises in the second access cycle
	wire acc_phase = psel && penable;
	wire acc_first = acc_phase && !pready;
	wire wr_commit = acc_phase && pready && pwrite;

	wire sel_ctrl  = (paddr == `RIO_OFF_CTRL);
	wire sel_flags = (paddr == `RIO_OFF_FLAGS);
	wire sel_ma1   = (paddr == `RIO_OFF_MASKA1);
	wire sel_ma2   = (paddr == `RIO_OFF_MASKA2);
	wire sel_mb1   = (paddr == `RIO_OFF_MASKB1);
	wire sel_mb2   = (paddr == `RIO_OFF_MASKB2);
	wire sel_pins  = (paddr == `RIO_OFF_PINS);
	wire sel_irqm  = (paddr == `RIO_OFF_IRQMASK);
	wire addr_hit  = sel_ctrl || sel_flags || sel_ma1 || sel_ma2
		|| sel_mb1 || sel_mb2 || sel_pins || sel_irqm;

	wire [`RIO_FLAG_W-1:0] flags_view = {batt_low_flag, watchdog_flag,
		stamp_flags, switchover_flag, alarm_flag, tick_flag};

	logic [`RIO_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_ctrl)
			rd_mux[`RIO_CTRL_W-1:0] = ctrl;
		else if (sel_flags)
			rd_mux[`RIO_FLAG_W-1:0] = flags_view;
		else if (sel_ma1)
			rd_mux[`RIO_M1_W-1:0] = mask_a1;
		else if (sel_ma2)
			rd_mux[`RIO_M2_W-1:0] = mask_a2;
		else if (sel_mb1)
			rd_mux[`RIO_M1_W-1:0] = mask_b1;
		else if (sel_mb2)
			rd_mux[`RIO_M2_W-1:0] = mask_b2;
		else if (sel_pins)
			rd_mux[2:0] = {pulse_state == rio_pkg::RIO_PULSE_ACTIVE,
				irq_out_b_oe, irq_out_a_oe};
		else if (sel_irqm)
			rd_mux[`RIO_FLAG_W-1:0] = irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc_first;
			prdata  <= acc_first ? rd_mux : '0;
			pslverr <= acc_first && !addr_hit;
		end
	end

	// ------------------------------------------------------------------------
	// Flag clear strobes, write one to clear
	// ------------------------------------------------------------------------
	wire        flag_wr   = wr_commit && sel_flags;
	wire        clr_tick  = flag_wr && pwdata[`RIO_F_TICK];
	wire        clr_alarm = flag_wr && pwdata[`RIO_F_AL];
	wire        clr_bsw   = flag_wr && pwdata[`RIO_F_BSW];
	wire [3:0]  clr_stamp = flag_wr ? pwdata[`RIO_F_TS +: 4] : 4'h0;

	// ------------------------------------------------------------------------
	// Event sources
	// ------------------------------------------------------------------------
	// Seconds win when both enabled: the minute tick coincides anyway
	wire set_tick = (ctrl[`RIO_C_SEC] && second_tick)
		|| (ctrl[`RIO_C_MIN] && !ctrl[`RIO_C_SEC] && minute_tick);

	// Group four is frozen once a switch-over was stamped and not cleared
	wire grp4_locked = ctrl[`RIO_C_BATT_STAMP_EN] && switchover_flag;
	wire bsw_capture = switch_rise && ctrl[`RIO_C_BATT_STAMP_EN]
		&& !switchover_flag;

	wire [3:0] set_stamp = {stamp_fall[3] && !grp4_locked,
		stamp_fall[2:0]};

	// ------------------------------------------------------------------------
	// Flags, set wins over clear
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_flag       <= 1'b0;
			alarm_flag      <= 1'b0;
			switchover_flag <= 1'b0;
			stamp_flags     <= 4'h0;
			watchdog_flag   <= 1'b0;
			batt_low_flag   <= 1'b0;
		end else begin
			tick_flag   <= set_tick || (tick_flag && !clr_tick);
			alarm_flag  <= alarm_event || (alarm_flag && !clr_alarm);
			stamp_flags <= set_stamp | (stamp_flags & ~clr_stamp);
			// Locked: further switch-overs leave the flag as it stands
			switchover_flag <= (switch_rise && !grp4_locked)
				|| (switchover_flag && !clr_bsw);
			watchdog_flag <= watchdog_level;
			batt_low_flag <= batt_low_now;
		end
	end

	// Capture strobe to the stamp store; switch-over only through group four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stamp_capture <= 4'h0;
		else
			stamp_capture <= {set_stamp[3] || bsw_capture,
				set_stamp[2:0]};
	end

	// ------------------------------------------------------------------------
	// Tick pulse generator
	// ------------------------------------------------------------------------
	// Pulse ends at the next 64 Hz strobe; ticks sit on that grid, so the
	// width is one period of it
	always_comb begin
		next_pulse_state = pulse_state;
		case (pulse_state)
			rio_pkg::RIO_PULSE_IDLE: begin
				if (set_tick && ctrl[`RIO_C_TP])
					next_pulse_state = rio_pkg::RIO_PULSE_ACTIVE;
			end
			rio_pkg::RIO_PULSE_ACTIVE: begin
				if (set_tick)
					next_pulse_state = rio_pkg::RIO_PULSE_ACTIVE;
				else if (clr_tick)
					next_pulse_state = rio_pkg::RIO_PULSE_IDLE;
				else if (tick_64hz || !ctrl[`RIO_C_TP])
					next_pulse_state = rio_pkg::RIO_PULSE_IDLE;
			end
			default: next_pulse_state = rio_pkg::RIO_PULSE_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pulse_state <= rio_pkg::RIO_PULSE_IDLE;
		else
			pulse_state <= next_pulse_state;
	end

	// Pulse form also needs the flag, so a clear cuts it at once
	wire tick_src = ctrl[`RIO_C_TP]
		? (pulse_state == rio_pkg::RIO_PULSE_ACTIVE && tick_flag)
		: tick_flag;

	// ------------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------------
	wire req_a = pin_request(ctrl, flags_view, tick_src,
		mask_a1, mask_a2);
	wire req_b = pin_request(ctrl, flags_view, tick_src,
		mask_b1, mask_b2);

	// Open drain: data stays low, only the enable moves; with no enables
	// set every request term is zero and the pins float
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_out_a_o  <= 1'b0;
			irq_out_b_o  <= 1'b0;
			irq_out_a_oe <= 1'b0;
			irq_out_b_oe <= 1'b0;
		end else begin
			irq_out_a_o  <= 1'b0;
			irq_out_b_o  <= 1'b0;
			irq_out_a_oe <= req_a;
			irq_out_b_oe <= req_b;
		end
	end

	// ------------------------------------------------------------------------
	// Software interrupt
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(flags_view & ~irq_mask);
	end

	// ------------------------------------------------------------------------
	// Control and mask registers
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= `RIO_CTRL_RST;
			irq_mask <= `RIO_IRQM_RST;
		end else begin
			if (wr_commit && sel_ctrl)
				ctrl <= pwdata[`RIO_CTRL_W-1:0];
			if (wr_commit && sel_irqm)
				irq_mask <= pwdata[`RIO_FLAG_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_a1 <= `RIO_M1_RST;
			mask_a2 <= `RIO_M2_RST;
			mask_b1 <= `RIO_M1_RST;
			mask_b2 <= `RIO_M2_RST;
		end else begin
			if (wr_commit && sel_ma1)
				mask_a1 <= pwdata[`RIO_M1_W-1:0];
			if (wr_commit && sel_ma2)
				mask_a2 <= pwdata[`RIO_M2_W-1:0];
			if (wr_commit && sel_mb1)
				mask_b1 <= pwdata[`RIO_M1_W-1:0];
			if (wr_commit && sel_mb2)
				mask_b2 <= pwdata[`RIO_M2_W-1:0];
		end
	end

endmodule

// >>> inc/rio_cfg.svh
// Register map, field positions and reset values of the interrupt output block
`ifndef RIO_CFG_SVH
`define RIO_CFG_SVH

// ----------------------------------------------------------------------------
// Bus
// ----------------------------------------------------------------------------
`define RIO_AW          8
`define RIO_DW          32
`define RIO_SYNC_W      6

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RIO_OFF_CTRL    8'h00
`define RIO_OFF_FLAGS   8'h04
`define RIO_OFF_MASKA1  8'h08
`define RIO_OFF_MASKA2  8'h0C
`define RIO_OFF_MASKB1  8'h10
`define RIO_OFF_MASKB2  8'h14
`define RIO_OFF_PINS    8'h18
`define RIO_OFF_IRQMASK 8'h1C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define RIO_CTRL_W      12
`define RIO_C_SEC       0
`define RIO_C_MIN       1
`define RIO_C_TP        2
`define RIO_C_WD        3
`define RIO_C_AL        4
`define RIO_C_BSW       5
`define RIO_C_BLOW      6
`define RIO_C_BATT_STAMP_EN      7
`define RIO_C_TS        8
`define RIO_CTRL_RST    12'h000

// ----------------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------------
`define RIO_FLAG_W      9
`define RIO_F_TICK      0
`define RIO_F_AL        1
`define RIO_F_BSW       2
`define RIO_F_TS        3
`define RIO_F_WD        7
`define RIO_F_BLOW      8
`define RIO_FLAG_RST    9'h000
`define RIO_IRQM_RST    9'h1FF

// ----------------------------------------------------------------------------
// Pin mask fields
// ----------------------------------------------------------------------------
`define RIO_M1_W        6
`define RIO_M2_W        4
`define RIO_M1_MIN      5
`define RIO_M1_SEC      4
`define RIO_M1_WD       3
`define RIO_M1_AL       2
`define RIO_M1_BSW      1
`define RIO_M1_BLOW     0
`define RIO_M1_RST      6'h3F
`define RIO_M2_RST      4'hF

`endif

// >>> inc/rio_pkg.sv
// Types shared by the interrupt output block
package rio_pkg;

	typedef enum logic {
		RIO_PULSE_IDLE,
		RIO_PULSE_ACTIVE
	} rio_pulse_state_t;

endpackage

// >>> logic/rio_sync.sv
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module rio_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule

// >>> tb/rio_irq_out_chk.sv
// Assertions on the interrupt pins of the output block
`timescale 1ns/1ps
`include "rio_cfg.svh"
module rio_irq_out_chk (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic [`RIO_AW-1:0] paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [`RIO_DW-1:0] pwdata,
	input wire logic               pready,
	input wire logic               second_tick,
	input wire logic               minute_tick,
	input wire logic               tick_64hz,
	input wire logic               alarm_event,
	input wire logic               watchdog_level,
	input wire logic               batt_low_pin,
	input wire logic               irq_out_a_o,
	input wire logic               irq_out_a_oe,
	input wire logic               irq_out_b_o,
	input wire logic               irq_out_b_oe
);
	logic [`RIO_CTRL_W-1:0] ctl;
	wire logic              wr_done;
	wire logic              off;

	assign wr_done = psel && penable && pready && pwrite;
	assign off = !irq_out_a_oe && !irq_out_b_oe;

	// ----------------
	// Control shadow
	// ----------------
	// Snooped from the bus so the checker knows which sources are enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= `RIO_CTRL_RST;
		end else if (wr_done && paddr == `RIO_OFF_CTRL) begin
			ctl <= pwdata[`RIO_CTRL_W-1:0];
		end
	end

	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_clr(b, c);
		wr_done && paddr == `RIO_OFF_FLAGS && pwdata[b] && c;
	endsequence
	// A tick one cycle earlier may restart the pulse on this edge
	sequence s_strobe;
		ctl == 12'h005 && tick_64hz && !second_tick && !$past(second_tick)
			##1 ctl == 12'h005;
	endsequence

	property p_od_a;
		irq_out_a_o == 1'b0;
	endproperty
	property p_od_b;
		irq_out_b_o == 1'b0;
	endproperty
	property p_idle;
		ctl == '0 && $past(ctl) == '0 |-> off;
	endproperty
	property p_pulse;
		s_strobe |-> ##1 off;
	endproperty
	property p_tick_clr;
		s_clr(`RIO_F_TICK,
			ctl[11:3] == '0 && !second_tick && !minute_tick)
			##1 ctl[11:3] == '0 |-> ##1 off;
	endproperty
	property p_al_clr;
		s_clr(`RIO_F_AL, ctl == 12'h010 && !alarm_event)
			##1 ctl == 12'h010 |-> ##1 off;
	endproperty
	property p_wd_rel;
		(ctl == 12'h008 && !watchdog_level) [*3] |-> off;
	endproperty
	property p_bl_rel;
		(ctl == 12'h040 && !batt_low_pin) [*6] |-> off;
	endproperty

	a_od_a: assert property (p_od_a)
		else $error("pin a data not low");
	a_od_b: assert property (p_od_b)
		else $error("pin b data not low");
	a_idle: assert property (p_idle)
		else $error("pin driven with all sources off");
	a_pulse: assert property (p_pulse)
		else $error("tick pulse outlived strobe");
	a_tick_clr: assert property (p_tick_clr)
		else $error("tick clear did not release");
	a_al_clr: assert property (p_al_clr)
		else $error("alarm clear did not release");
	a_wd_rel: assert property (p_wd_rel)
		else $error("watchdog low but pin driven");
	a_bl_rel: assert property (p_bl_rel)
		else $error("battery ok but pin driven");
endmodule

bind rio_irq_out rio_irq_out_chk u_chk (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
	.second_tick, .minute_tick, .tick_64hz, .alarm_event, .watchdog_level,
	.batt_low_pin, .irq_out_a_o, .irq_out_a_oe, .irq_out_b_o, .irq_out_b_oe
);

// >>> tb/rio_host_pin.sv
// Host interrupt inputs with pull-ups on both open-drain lines
`timescale 1ns/1ps
module rio_host_pin (
	input  wire logic a_o,
	input  wire logic a_oe,
	input  wire logic b_o,
	input  wire logic b_oe,
	output logic      line_a,
	output logic      line_b
);
	// Released line floats up to the pull-up level
	assign line_a = a_oe ? a_o : 1'b1;
	assign line_b = b_oe ? b_o : 1'b1;
endmodule

// >>> tb/rio_irq_out_tb.sv
// Self-checking bench for the interrupt output block
`timescale 1ns/1ps
`include "rio_cfg.svh"
module rio_irq_out_tb;
	logic               pclk, presetn, psel, penable, pwrite, pready;
	logic               pslverr, second_tick, minute_tick, tick_64hz;
	logic               alarm_event, watchdog_level, switchover_pin;
	logic               batt_low_pin, irq, line_a, line_b;
	logic               irq_out_a_o, irq_out_a_oe;
	logic               irq_out_b_o, irq_out_b_oe;
	logic [`RIO_AW-1:0] paddr;
	logic [`RIO_DW-1:0] pwdata, prdata, seed;
	logic [3:0]         stamp_pins_n, stamp_capture;
	logic [32:0]        expq[$];
	logic [11:0]        tctl[5] = '{12'h0, 12'h2, 12'h2, 12'h1, 12'h3};
	logic [3:0]         tev[5] = '{4'h8, 4'h8, 4'h4, 4'h8, 4'h8};
	logic               texp[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	int                 miscompares = 0, num_checks = 0, cap4 = 0, n0;
	int                 caps = 0;

	rio_irq_out DUT (.*);
	rio_host_pin u_host (.a_o(irq_out_a_o), .a_oe(irq_out_a_oe),
		.b_o(irq_out_b_o), .b_oe(irq_out_b_oe), .line_a, .line_b);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic cyc(int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(string what, logic [32:0] e, logic [32:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following setup never reassigns psel here
		@(posedge pclk);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(logic [7:0] a, logic [32:0] e);
		expq.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic ev(logic [3:0] m);
		{second_tick, minute_tick, tick_64hz, alarm_event} <= m;
		cyc(1);
		{second_tick, minute_tick, tick_64hz, alarm_event} <= 4'h0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------------
	// Watchers
	// ----------------
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk($sformatf("read %h", paddr), expq.pop_front(),
				{pslverr, prdata});
		end
		if (stamp_capture[3] === 1'b1) begin
			cap4++;
		end
		caps += $countones(stamp_capture);
	end
	initial begin
		cyc(5000);
		miscompares++;
		results();
	end

	// ----------------
	// Scenarios
	// ----------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{second_tick, minute_tick, tick_64hz, alarm_event} = 4'h0;
		{watchdog_level, switchover_pin, batt_low_pin} = 3'h0;
		stamp_pins_n = 4'hF;
		presetn = 1'b0;
		seed = 32'h00008CEB;
		cyc(5);
		presetn <= 1'b1;
		cyc(1);
		rd(`RIO_OFF_CTRL, 33'h0);
		rd(`RIO_OFF_FLAGS, 33'h0);
		rd(`RIO_OFF_MASKA1, 33'h3F);
		rd(`RIO_OFF_MASKA2, 33'hF);
		rd(`RIO_OFF_MASKB1, 33'h3F);
		rd(`RIO_OFF_MASKB2, 33'hF);
		rd(`RIO_OFF_PINS, 33'h0);
		rd(`RIO_OFF_IRQMASK, 33'h1FF);
		rd(8'h20, 33'h100000000);
		$display("reset values done");
		wr(`RIO_OFF_MASKA1, 32'h0);
		wr(`RIO_OFF_MASKA2, 32'h0);
		wr(`RIO_OFF_MASKB1, 32'h0);
		wr(`RIO_OFF_MASKB2, 32'h0);
		ev(4'hF);
		{watchdog_level, batt_low_pin, stamp_pins_n} <= 6'h30;
		cyc(6);
		rd(`RIO_OFF_PINS, 33'h0);
		chk("line_a", 1'b1, line_a);
		{watchdog_level, batt_low_pin, stamp_pins_n} <= 6'h0F;
		cyc(6);
		wr(`RIO_OFF_FLAGS, 32'h7F);
		$display("disabled sources done");
		for (int i = 0; i < 5; i++) begin
			wr(`RIO_OFF_CTRL, 32'(tctl[i]));
			ev(tev[i]);
			cyc(2);
			chk("tick line", !texp[i], line_a);
			rd(`RIO_OFF_FLAGS, 33'(texp[i]));
			wr(`RIO_OFF_FLAGS, 32'h1);
			cyc(2);
			chk("tick line", 1'b1, line_a);
		end
		wr(`RIO_OFF_CTRL, 32'h5);
		ev(4'h8);
		cyc(1);
		rd(`RIO_OFF_PINS, 33'h7);
		ev(4'h2);
		cyc(1);
		rd(`RIO_OFF_PINS, 33'h0);
		rd(`RIO_OFF_FLAGS, 33'h1);
		wr(`RIO_OFF_FLAGS, 32'h1);
		ev(4'h8);
		cyc(1);
		wr(`RIO_OFF_FLAGS, 32'h1);
		rd(`RIO_OFF_PINS, 33'h0);
		$display("tick pulse done");
		wr(`RIO_OFF_CTRL, 32'h10);
		ev(4'h1);
		cyc(2);
		rd(`RIO_OFF_PINS, 33'h3);
		chk("line_b", 1'b0, line_b);
		wr(`RIO_OFF_MASKA1, 32'h3F);
		wr(`RIO_OFF_MASKA2, 32'hF);
		cyc(2);
		chk("line_a", 1'b1, line_a);
		rd(`RIO_OFF_FLAGS, 33'h2);
		wr(`RIO_OFF_FLAGS, 32'h2);
		rd(`RIO_OFF_PINS, 33'h0);
		wr(`RIO_OFF_CTRL, 32'h8);
		watchdog_level <= 1'b1;
		cyc(3);
		rd(`RIO_OFF_PINS, 33'h2);
		wr(`RIO_OFF_FLAGS, 32'h80);
		rd(`RIO_OFF_FLAGS, 33'h80);
		watchdog_level <= 1'b0;
		cyc(3);
		rd(`RIO_OFF_PINS, 33'h0);
		wr(`RIO_OFF_CTRL, 32'h40);
		cyc(6);
		batt_low_pin <= 1'b1;
		cyc(6);
		rd(`RIO_OFF_PINS, 33'h2);
		batt_low_pin <= 1'b0;
		cyc(6);
		rd(`RIO_OFF_PINS, 33'h0);
		batt_low_pin <= 1'b1;
		cyc(6);
		wr(`RIO_OFF_CTRL, 32'h0);
		rd(`RIO_OFF_PINS, 33'h0);
		batt_low_pin <= 1'b0;
		cyc(6);
		rd(`RIO_OFF_FLAGS, 33'h0);
		wr(`RIO_OFF_CTRL, 32'hF00);
		for (int i = 0; i < 4; i++) begin
			n0 = caps;
			stamp_pins_n[i] <= 1'b0;
			cyc(6);
			chk("capture", n0 + 1, caps);
			rd(`RIO_OFF_FLAGS, 33'h8 << i);
			rd(`RIO_OFF_PINS, 33'h2);
			stamp_pins_n[i] <= 1'b1;
			wr(`RIO_OFF_FLAGS, 32'h8 << i);
			rd(`RIO_OFF_PINS, 33'h0);
		end
		$display("level sources done");
		n0 = cap4;
		wr(`RIO_OFF_CTRL, 32'h20);
		switchover_pin <= 1'b1;
		cyc(6);
		rd(`RIO_OFF_FLAGS, 33'h4);
		chk("capture", n0, cap4);
		switchover_pin <= 1'b0;
		wr(`RIO_OFF_FLAGS, 32'h4);
		wr(`RIO_OFF_CTRL, 32'hA0);
		switchover_pin <= 1'b1;
		cyc(6);
		chk("capture", n0 + 1, cap4);
		switchover_pin <= 1'b0;
		cyc(6);
		{switchover_pin, stamp_pins_n} <= 5'h17;
		cyc(6);
		chk("capture", n0 + 1, cap4);
		rd(`RIO_OFF_FLAGS, 33'h4);
		{switchover_pin, stamp_pins_n} <= 5'h0F;
		wr(`RIO_OFF_FLAGS, 32'h4);
		$display("switch-over done");
		wr(`RIO_OFF_CTRL, 32'h0);
		wr(`RIO_OFF_IRQMASK, 32'h1FD);
		ev(4'h1);
		cyc(2);
		chk("irq", 1'b1, irq);
		wr(`RIO_OFF_IRQMASK, 32'h1FF);
		cyc(2);
		chk("irq", 1'b0, irq);
		wr(`RIO_OFF_FLAGS, 32'h2);
		repeat (4) begin
			seed = xs(seed);
			wr(`RIO_OFF_MASKB1, seed);
			rd(`RIO_OFF_MASKB1, {1'b0, seed & 32'h3F});
		end
		$display("irq and masks done");
		cyc(2);
		if (expq.size() != 0) begin
			miscompares++;
		end
		results();
	end
endmodule
